// file: twtl_pkg.sv
package twtl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // word lengths and edge numbers
  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned WORD_SHORT = 18; // 14-bit divider word
  localparam int unsigned WORD_MID = 19; // 15-bit divider word
  localparam int unsigned WORD_LONG = 27; // divider plus control byte
  localparam int unsigned PORT_BITS = 4; // leading port bits
  localparam int unsigned PORT_LOAD_EDGE = 5; // rising edge that loads ports
  localparam int unsigned FREQ_LOAD_EDGE = 20; // rising edge that loads divider
  localparam int unsigned FREQ_W = 15; // divider width
  localparam int unsigned SHIFT_W = 27; // input shift register width
  localparam int unsigned CNT_W = 5; // pulse counter width
  localparam int unsigned RATIO_W = 8; // decoded ratio width

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  ////////////////////////////////////////////////////////////////////////////
  // port nibble, bit 3 is the first bit received
  localparam int unsigned PORT_FM_POS = 3;
  localparam int unsigned PORT_UHF_POS = 2;
  localparam int unsigned PORT_LOWER_BAND_HIGH_PORT_REGISTER_POS = 1;
  localparam int unsigned PORT_LOWER_BAND_LOW_PORT_REGISTER_POS = 0;
  // control byte, last eight bits of a long word, bit 7 is a fixed one
  localparam int unsigned CTRL_CP_POS = 6;
  localparam int unsigned CTRL_T2_POS = 5;
  localparam int unsigned CTRL_T1_POS = 4;
  localparam int unsigned CTRL_T0_POS = 3;
  localparam int unsigned CTRL_RSA_POS = 2;
  localparam int unsigned CTRL_RSB_POS = 1;
  localparam int unsigned CTRL_OS_POS = 0;

  ////////////////////////////////////////////////////////////////////////////
  // power-on values
  ////////////////////////////////////////////////////////////////////////////
  localparam logic CP_RST = 1'h1; // high pump current
  localparam logic [2:0] TEST_RST = 3'h1; // normal mode pattern
  localparam logic RSA_RST = 1'h1;
  localparam logic RSB_RST = 1'h1;
  localparam logic OS_RST = 1'h1; // tuning amplifier off
  localparam logic [3:0] PORT_RST = 4'h0; // all bands off
  localparam logic [14:0] FREQ_RST = 15'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // reference divider ratios
  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] RATIO_80 = 8'h50;
  localparam logic [7:0] RATIO_128 = 8'h80;
  localparam logic [7:0] RATIO_64 = 8'h40;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  ////////////////////////////////////////////////////////////////////////////
  // band port outputs
  typedef struct packed {
    logic fm_stereo_port_output;
    logic uhf_port_output;
    logic vhf_high_port_output;
    logic vhf_low_port_output;
  } twtl_ports_t;

  // control settings
  typedef struct packed {
    logic pump_current_select;
    logic test_mode_bit_high;
    logic test_mode_bit_mid;
    logic test_mode_bit_low;
    logic ratio_select_a;
    logic ratio_select_b;
    logic tuning_amp_off_bit;
  } twtl_ctrl_t;

  // frame state
  typedef enum logic [0:0] {
    TWTL_IDLE = 1'b0,
    TWTL_FRAME = 1'b1
  } twtl_state_t;

endpackage

// file: twtl_sync.sv
module twtl_sync #(
  parameter int unsigned W = 3
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_prev,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);

  ////////////////////////////////////////////////////////////////////////////
  // per-bit two-flop synchroniser plus one history stage
  ////////////////////////////////////////////////////////////////////////////
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic meta_q; // first stage, read only by second
      logic sync_q; // second stage
      logic hist_q; // one cycle older
      // pipeline
      always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
          hist_q <= 1'b0;
        end else begin
          meta_q <= i_async[gi];
          sync_q <= meta_q;
          hist_q <= sync_q;
        end
      end
      // edges from the settled stages only
      assign o_level[gi] = sync_q;
      assign o_prev[gi] = hist_q;
      assign o_rise[gi] = sync_q & ~hist_q;
      assign o_fall[gi] = hist_q & ~sync_q;
    end
  endgenerate

endmodule

// file: twtl_ratio_dec.sv
module twtl_ratio_dec (
  input wire logic i_ratio_select_a,
  input wire logic i_ratio_select_b,
  output logic [7:0] o_ratio
);

  ////////////////////////////////////////////////////////////////////////////
  // reference divider ratio from the two select bits
  ////////////////////////////////////////////////////////////////////////////
  // b low wins regardless of a
  assign o_ratio = !i_ratio_select_b ? twtl_pkg::RATIO_80 :
                   (i_ratio_select_a ? twtl_pkg::RATIO_64 : twtl_pkg::RATIO_128);

endmodule

// file: twtl_loader.sv
module twtl_loader #(
  parameter int unsigned FREQ_W = twtl_pkg::FREQ_W,
  parameter int unsigned SHIFT_W = twtl_pkg::SHIFT_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_chip_enable_line,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_bus_format_select_pin,
  output twtl_pkg::twtl_ports_t o_ports,
  output twtl_pkg::twtl_ctrl_t o_ctrl,
  output logic [FREQ_W-1:0] o_freq_word,
  output logic [7:0] o_ref_ratio,
  output logic o_tuning_voltage_output_en,
  output logic o_word_done
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] pin_raw; // pins bundled for the synchroniser
  logic [3:0] pin_level; // settled levels
  logic [3:0] pin_prev; // levels one cycle older
  logic [3:0] pin_rise; // rising edges
  logic [3:0] pin_fall; // falling edges

  // bit order: enable, clock, data, format select
  assign pin_raw = {i_bus_format_select_pin, i_ser_data, i_ser_clk, i_chip_enable_line};

  // two flops on every pin
  twtl_sync #(
    .W(4)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async(pin_raw),
    .o_level(pin_level),
    .o_prev(pin_prev),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // named pin events
  ////////////////////////////////////////////////////////////////////////////
  logic mode_3wire; // format pin high selects the 3-wire load
  logic en_level; // enable window open
  logic en_rise; // window opens
  logic en_fall; // window closes
  logic clk_rise; // serial clock rising edge
  logic clk_fall; // serial clock falling edge
  logic data_bit; // data as it stood before the clock fell

  assign mode_3wire = pin_level[3];
  assign en_level = pin_level[0] & mode_3wire;
  assign en_rise = pin_rise[0] & mode_3wire;
  assign en_fall = pin_fall[0] & mode_3wire;
  assign clk_rise = pin_rise[1];
  assign clk_fall = pin_fall[1];
  assign data_bit = pin_prev[2];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  ////////////////////////////////////////////////////////////////////////////
  twtl_pkg::twtl_state_t state_q; // idle or inside a frame
  twtl_pkg::twtl_state_t state_d;
  logic [SHIFT_W-1:0] shift_q; // serial input shift register
  logic [SHIFT_W-1:0] shift_d;
  logic [4:0] bits_q; // falling edges seen in this frame
  logic [4:0] bits_d;
  logic [4:0] rises_q; // rising edges seen in this frame
  logic [4:0] rises_d;
  logic [3:0] ports_q; // band-switch register
  logic [3:0] ports_d;
  logic [FREQ_W-1:0] freq_q; // frequency register
  logic [FREQ_W-1:0] freq_d;
  twtl_pkg::twtl_ctrl_t ctrl_q; // control register
  twtl_pkg::twtl_ctrl_t ctrl_d;
  logic first_q; // no short word seen since power-on
  logic first_d;
  logic done_q; // one-cycle pulse at a valid word end
  logic done_d;

  ////////////////////////////////////////////////////////////////////////////
  // frame decode
  ////////////////////////////////////////////////////////////////////////////
  logic in_frame; // frame active and enable still high
  logic shift_now; // take one data bit
  logic count_rise; // count one rising edge
  logic [4:0] rise_num; // number of the rising edge now seen
  logic port_load; // this rise loads the ports
  logic freq_load_long; // this rise loads the divider of a long word
  logic len_short; // 18 bits at enable fall
  logic len_mid; // 19 bits at enable fall
  logic len_long; // 27 bits at enable fall
  logic word_end; // enable fell at the end of a frame

  assign in_frame = (state_q == twtl_pkg::TWTL_FRAME) & en_level;

  assign shift_now = in_frame & clk_fall & (bits_q != 5'h1f);

  assign count_rise = in_frame & clk_rise & (rises_q != 5'h1f);
  assign rise_num = rises_q + 5'h01;

  assign port_load = count_rise & (rise_num == 5'(twtl_pkg::PORT_LOAD_EDGE));

  assign freq_load_long = count_rise & (rise_num == 5'(twtl_pkg::FREQ_LOAD_EDGE));

  assign word_end = (state_q == twtl_pkg::TWTL_FRAME) & en_fall;
  assign len_short = word_end & (bits_q == 5'(twtl_pkg::WORD_SHORT));
  assign len_mid = word_end & (bits_q == 5'(twtl_pkg::WORD_MID));
  assign len_long = word_end & (bits_q == 5'(twtl_pkg::WORD_LONG));

  ////////////////////////////////////////////////////////////////////////////
  // field extraction
  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] port_field; // first four bits received
  logic [FREQ_W-1:0] freq_mid; // 15 divider bits of a 19-bit word
  logic [FREQ_W-1:0] freq_short; // 14 divider bits, top forced low
  logic [FREQ_W-1:0] freq_long; // divider as held at the 20th rise
  logic [7:0] ctrl_byte; // last eight bits of a long word

  assign port_field = shift_q[3:0];
  assign freq_short = {1'b0, shift_q[FREQ_W-2:0]};
  assign freq_mid = shift_q[FREQ_W-1:0];
  assign freq_long = shift_q[FREQ_W-1:0];
  assign ctrl_byte = shift_q[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // frame state machine
  ////////////////////////////////////////////////////////////////////////////
  // a frame opens on enable rise and closes on enable fall
  always_comb begin
    state_d = state_q;
    case (state_q)
      twtl_pkg::TWTL_IDLE: begin
        if (en_rise) begin
          state_d = twtl_pkg::TWTL_FRAME;
        end
      end
      twtl_pkg::TWTL_FRAME: begin
        if (!en_level) begin
          state_d = twtl_pkg::TWTL_IDLE;
        end
      end
      default: begin
        state_d = twtl_pkg::TWTL_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // shifter and counters
  ////////////////////////////////////////////////////////////////////////////
  // counters restart each frame, shift register is MSB first
  always_comb begin
    shift_d = shift_q;
    bits_d = bits_q;
    rises_d = rises_q;
    if (en_rise) begin
      // new window
      bits_d = 5'h00;
      rises_d = 5'h00;
    end else begin
      if (shift_now) begin
        shift_d = {shift_q[SHIFT_W-2:0], data_bit};
        bits_d = bits_q + 5'h01;
      end
      if (count_rise) begin
        rises_d = rise_num;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port register
  ////////////////////////////////////////////////////////////////////////////
  // port load
  assign ports_d = port_load ? port_field : ports_q;

  ////////////////////////////////////////////////////////////////////////////
  // frequency register
  ////////////////////////////////////////////////////////////////////////////
  // short words load at the close, any frame reaching the 20th rise loads mid-frame; others leave it
  always_comb begin
    freq_d = freq_q;
    if (freq_load_long) begin
      freq_d = freq_long;
    end else if (len_short) begin
      freq_d = freq_short;
    end else if (len_mid) begin
      freq_d = freq_mid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register
  ////////////////////////////////////////////////////////////////////////////
  // long words set all control bits; short words touch ratio a, and the first one also clears the amplifier off bit
  always_comb begin
    ctrl_d = ctrl_q;
    if (len_long) begin
      ctrl_d.pump_current_select = ctrl_byte[twtl_pkg::CTRL_CP_POS];
      ctrl_d.test_mode_bit_high = ctrl_byte[twtl_pkg::CTRL_T2_POS];
      ctrl_d.test_mode_bit_mid = ctrl_byte[twtl_pkg::CTRL_T1_POS];
      ctrl_d.test_mode_bit_low = ctrl_byte[twtl_pkg::CTRL_T0_POS];
      ctrl_d.ratio_select_b = ctrl_byte[twtl_pkg::CTRL_RSB_POS];
      ctrl_d.tuning_amp_off_bit = ctrl_byte[twtl_pkg::CTRL_OS_POS];
      ctrl_d.ratio_select_a = ctrl_byte[twtl_pkg::CTRL_RSA_POS];
    end else if (len_short) begin
      ctrl_d.ratio_select_a = 1'b1;
    end else if (len_mid) begin
      ctrl_d.ratio_select_a = 1'b0;
    end
    if ((len_short | len_mid) & first_q) begin
      ctrl_d.tuning_amp_off_bit = 1'b0;
    end
  end

  // short-word tracking and word-end pulse
  assign first_d = (len_short | len_mid) ? 1'b0 : first_q;
  assign done_d = len_short | len_mid | len_long;

  ////////////////////////////////////////////////////////////////////////////
  // flops
  ////////////////////////////////////////////////////////////////////////////
  // power-on defaults
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= twtl_pkg::TWTL_IDLE;
      shift_q <= '0;
      bits_q <= 5'h00;
      rises_q <= 5'h00;
      done_q <= 1'b0;
      first_q <= 1'b1;
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bits_q <= bits_d;
      rises_q <= rises_d;
      done_q <= done_d;
      first_q <= first_d;
    end
  end

  // stored settings
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ports_q <= twtl_pkg::PORT_RST;
      freq_q <= FREQ_W'(twtl_pkg::FREQ_RST);
      ctrl_q.pump_current_select <= twtl_pkg::CP_RST;
      {ctrl_q.test_mode_bit_high, ctrl_q.test_mode_bit_mid,
       ctrl_q.test_mode_bit_low} <= twtl_pkg::TEST_RST;
      ctrl_q.ratio_select_a <= twtl_pkg::RSA_RST;
      ctrl_q.ratio_select_b <= twtl_pkg::RSB_RST;
      ctrl_q.tuning_amp_off_bit <= twtl_pkg::OS_RST;
    end else begin
      ports_q <= ports_d;
      freq_q <= freq_d;
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ratio decode
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ratio_w; // decoded reference ratio

  twtl_ratio_dec u_ratio (
    .i_ratio_select_a(ctrl_q.ratio_select_a),
    .i_ratio_select_b(ctrl_q.ratio_select_b),
    .o_ratio(ratio_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  ////////////////////////////////////////////////////////////////////////////
  // port follows bit
  // one driver for the whole struct, fields in declared order
  assign o_ports = {ports_q[twtl_pkg::PORT_FM_POS],
                    ports_q[twtl_pkg::PORT_UHF_POS],
                    ports_q[twtl_pkg::PORT_LOWER_BAND_HIGH_PORT_REGISTER_POS],
                    ports_q[twtl_pkg::PORT_LOWER_BAND_LOW_PORT_REGISTER_POS]};
  assign o_ctrl = ctrl_q;
  assign o_freq_word = freq_q;
  assign o_ref_ratio = ratio_w;
  assign o_tuning_voltage_output_en = ~ctrl_q.tuning_amp_off_bit;
  assign o_word_done = done_q;

endmodule

// file: twtl_loader_asserts.sv
module twtl_loader_chk #(
  parameter int unsigned FREQ_W = 15,
  parameter int unsigned SHIFT_W = 27
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_chip_enable_line,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_bus_format_select_pin,
  input wire twtl_pkg::twtl_ports_t o_ports,
  input wire twtl_pkg::twtl_ctrl_t o_ctrl,
  input wire logic [FREQ_W-1:0] o_freq_word,
  input wire logic [7:0] o_ref_ratio,
  input wire logic o_tuning_voltage_output_en,
  input wire logic o_word_done
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // one clock domain, reset disables all checks
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // tuning output mirrors the amplifier off bit
  property p_vt_en;
    o_tuning_voltage_output_en == !o_ctrl.tuning_amp_off_bit;
  endproperty
  a_vt_en: assert property (p_vt_en)
    else $error("tuning enable disagrees with amplifier bit");

  // ratio decode, b low
  property p_ratio_80;
    !o_ctrl.ratio_select_b |-> o_ref_ratio == 8'h50;
  endproperty
  a_ratio_80: assert property (p_ratio_80)
    else $error("ratio not 80 with select b low");

  // ratio decode, a low and b high
  property p_ratio_128;
    o_ctrl.ratio_select_b && !o_ctrl.ratio_select_a |-> o_ref_ratio == 8'h80;
  endproperty
  a_ratio_128: assert property (p_ratio_128)
    else $error("ratio not 128");

  // ratio decode, both high
  property p_ratio_64;
    o_ctrl.ratio_select_b && o_ctrl.ratio_select_a |-> o_ref_ratio == 8'h40;
  endproperty
  a_ratio_64: assert property (p_ratio_64)
    else $error("ratio not 64");

  // done is a single cycle pulse
  property p_done_pulse;
    o_word_done |=> !o_word_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("word done longer than one cycle");

  // done only follows an enable fall
  property p_done_cause;
    o_word_done |-> !$past(i_chip_enable_line) && $past(i_chip_enable_line, 5);
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("word done without enable fall");

  // control bits move only when a word completes
  property p_ctrl_at_done;
    $changed(o_ctrl) |-> o_word_done;
  endproperty
  a_ctrl_at_done: assert property (p_ctrl_at_done)
    else $error("control changed outside word end");

  // divider moves at word end or inside an open frame
  property p_freq_cause;
    $changed(o_freq_word) |->
      o_word_done || ($past(i_chip_enable_line, 3) && $past(i_bus_format_select_pin, 3));
  endproperty
  a_freq_cause: assert property (p_freq_cause)
    else $error("frequency changed without a valid load");

  // band ports load only inside an enabled frame
  property p_ports_cause;
    $changed(o_ports) |-> $past(i_chip_enable_line, 3) && $past(i_bus_format_select_pin, 3);
  endproperty
  a_ports_cause: assert property (p_ports_cause)
    else $error("ports changed outside a frame");

  // helper: a complete word has been accepted since reset
  logic seen_q;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      seen_q <= 1'h0;
    end else if (o_word_done) begin
      seen_q <= 1'h1;
    end
  end

  // amplifier stays off until the first word lands
  property p_amp_hold;
    !seen_q && !o_word_done |-> !o_tuning_voltage_output_en;
  endproperty
  a_amp_hold: assert property (p_amp_hold)
    else $error("tuning enabled before any word");
endmodule

bind twtl_loader twtl_loader_chk #(.FREQ_W(FREQ_W), .SHIFT_W(SHIFT_W)) twtl_loader_chk_i (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_chip_enable_line(i_chip_enable_line),
  .i_ser_clk(i_ser_clk),
  .i_ser_data(i_ser_data),
  .i_bus_format_select_pin(i_bus_format_select_pin),
  .o_ports(o_ports),
  .o_ctrl(o_ctrl),
  .o_freq_word(o_freq_word),
  .o_ref_ratio(o_ref_ratio),
  .o_tuning_voltage_output_en(o_tuning_voltage_output_en),
  .o_word_done(o_word_done)
);

// file: twtl_ctl_model.sv
module twtl_ctl_model (
  input wire logic i_core_clk,
  output logic o_chip_enable_line,
  output logic o_ser_clk,
  output logic o_ser_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle: enable low, serial clock parked low
  initial begin
    o_chip_enable_line = 1'b0;
    o_ser_clk = 1'b0;
    o_ser_data = 1'b0;
  end

  // wait n falling core edges
  task automatic idle(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // one framed word, msb first, ph core clocks per phase (4 or more)
  ////////////////////////////////////////////////////////////////////////////
  // caller picks the pulse count
  task automatic send(input int len, input logic [26:0] w, input int ph);
    int i;
    idle(1);
    o_chip_enable_line = 1'b1;
    idle(5);
    for (i = len - 1; i >= 0; i--) begin
      o_ser_data = w[i];
      idle(ph);
      o_ser_clk = 1'b1;
      idle(ph);
      o_ser_clk = 1'b0;
      idle(ph);
    end
    o_chip_enable_line = 1'b0;
    // released data line must not keep the last bit
    o_ser_data = ~o_ser_data;
    idle(8);
  endtask
endmodule

// file: three_wire_tuner_word_loader_tb.sv
`define CHK(got, exp, msg) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("mismatch %0t %s", $time, msg); \
    end \
  end

module three_wire_tuner_word_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk; // 50 mhz
  logic rst; // async, active high
  logic en, sclk, sdata; // serial pins from the controller
  logic fmt; // format select pin
  twtl_pkg::twtl_ports_t ports;
  twtl_pkg::twtl_ctrl_t ctrl;
  logic [14:0] freq;
  logic [7:0] ratio;
  logic vt_en, done;
  int fails = 0;
  int tests_run = 0;
  int dones = 0; // word done pulses seen

  ////////////////////////////////////////////////////////////////////////////
  // instances
  ////////////////////////////////////////////////////////////////////////////
  twtl_loader twtl_loader_i (
    .i_core_clk(core_clk), .i_rst(rst), .i_chip_enable_line(en),
    .i_ser_clk(sclk), .i_ser_data(sdata), .i_bus_format_select_pin(fmt),
    .o_ports(ports), .o_ctrl(ctrl), .o_freq_word(freq), .o_ref_ratio(ratio),
    .o_tuning_voltage_output_en(vt_en), .o_word_done(done)
  );
  twtl_ctl_model twtl_ctl_model_i (
    .i_core_clk(core_clk), .o_chip_enable_line(en), .o_ser_clk(sclk), .o_ser_data(sdata)
  );

  // clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // count completion pulses
  always @(posedge core_clk) begin
    if (done === 1'b1) dones++;
  end

  // verdict and end of run
  task give_verdict;
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // compare every output against expectations
  task check(input logic [3:0] ep, input logic [6:0] ec, input logic [14:0] ef,
             input logic [7:0] er, input int ed);
    `CHK(ports, ep, "band ports")
    `CHK(ctrl, ec, "control bits")
    `CHK(freq, ef, "frequency word")
    `CHK(ratio, er, "reference ratio")
    `CHK(vt_en, ~ec[0], "tuning enable")
    `CHK(dones, ed, "word done count")
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  ////////////////////////////////////////////////////////////////////////////
  // defaults after reset, d words done so far
  task sc_defaults(input int d);
    check(4'h0, 7'h4f, 15'h0000, 8'h40, d);
  endtask

  // first word is 19 bits: a cleared, amplifier on
  task sc_first19;
    twtl_ctl_model_i.send(19, {8'h00, 4'ha, 15'h4321}, 4);
    check(4'ha, 7'h4a, 15'h4321, 8'h80, 1);
  endtask

  // 18 bits, slow clock: top divider bit zero, a set
  task sc_short18;
    twtl_ctl_model_i.send(18, {9'h000, 4'h5, 14'h3fff}, 8);
    check(4'h5, 7'h4e, 15'h3fff, 8'h40, 2);
  endtask

  // 27 bits: control byte 1,cp0,t110,a1,b0,os1
  task sc_long;
    twtl_ctl_model_i.send(27, {4'h3, 15'h7abc, 8'hb5}, 4);
    check(4'h3, 7'h35, 15'h7abc, 8'h50, 3);
  endtask

  // later 19 bits keep control, clear a only
  task sc_keep19;
    twtl_ctl_model_i.send(19, {8'h00, 4'hc, 15'h0101}, 4);
    check(4'hc, 7'h31, 15'h0101, 8'h50, 4);
  endtask

  // ten pulses: ports load, divider stays
  task sc_partial;
    twtl_ctl_model_i.send(10, {17'h00000, 10'h2aa}, 4);
    check(4'ha, 7'h31, 15'h0101, 8'h50, 4);
  endtask

  // format pin low: frame ignored
  task sc_fmt_off;
    fmt = 1'b0;
    twtl_ctl_model_i.send(18, {9'h000, 4'h5, 14'h0fff}, 4);
    fmt = 1'b1;
    check(4'ha, 7'h31, 15'h0101, 8'h50, 4);
  endtask

  // twenty pulses, cut: divider loads at the 20th rise, control stays
  task sc_cut20;
    twtl_ctl_model_i.send(20, {7'h00, 4'h6, 15'h1234, 1'h1}, 4);
    check(4'h6, 7'h31, 15'h1234, 8'h50, 4);
  endtask

  // reset in mid run restores defaults
  task sc_rerun;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    sc_defaults(4);
  endtask

  // watchdog
  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    $display("mismatch %0t run hung", $time);
    give_verdict;
  end

  // main sequence
  initial begin
    rst = 1'b1;
    fmt = 1'b1;
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    sc_defaults(0);
    sc_first19;
    sc_short18;
    sc_long;
    sc_keep19;
    sc_partial;
    sc_fmt_off;
    sc_cut20;
    sc_rerun;
    give_verdict;
  end
endmodule
